//--- design/host_serial_pkg.sv
// Shared constants and carriers for the host serial port configuration block
package host_serial_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned BITS_PER_CHAR = 10;        // Start, eight data, one stop
   localparam int          DIV_W         = 17;
   localparam int          CHAR_W        = 21;

   // ==========================================================
   // Rate select encoding and limits
   localparam logic [19:0] RATE_STD_MAX  = 20'h00007;
   localparam logic [19:0] RATE_LIT_MIN  = 20'h00080;
   localparam logic [19:0] RATE_LIT_MAX  = 20'h3d090;
   localparam logic [19:0] RATE_RST      = 20'h00003;

   // ==========================================================
   // Other settings: reset values and limits
   localparam logic [7:0]  GAP_RST       = 8'h03;
   localparam logic [1:0]  IFACE_RST     = 2'h0;
   localparam logic [1:0]  IFACE_MAX     = 2'h2;
   localparam logic [2:0]  PARITY_RST    = 3'h0;
   localparam logic [2:0]  PARITY_MAX    = 3'h4;
   localparam logic [7:0]  PULL_MAP_RST  = 8'hff;
   localparam logic [7:0]  DIR_MAP_RST   = 8'hff;
   localparam int          PKT_MAX       = 100;

   // Pull map bit positions
   localparam int PULL_DIO4 = 0;
   localparam int PULL_DIO3 = 1;
   localparam int PULL_DIO2 = 2;
   localparam int PULL_DIO1 = 3;
   localparam int PULL_DIO0 = 4;
   localparam int PULL_RTS  = 5;
   localparam int PULL_SLP  = 6;
   localparam int PULL_DIN  = 7;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      SEL_RATE, SEL_GAP, SEL_IFACE, SEL_PARITY, SEL_PULL_MAP, SEL_DIR_MAP
   } cfg_sel_t;

   typedef struct packed {
      logic        we;
      cfg_sel_t    sel;
      logic [19:0] data;
   } cfg_req_t;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } pkt_beat_t;

   typedef enum logic [1:0] {RATE_IDLE, RATE_DIV1, RATE_DIV2} rate_fsm_t;

   // Bit period in clocks for a standard code; code 7 rounds to 111,111 b/s
   function automatic logic [DIV_W-1:0] std_div(input logic [2:0] code);
      unique case (code)
         3'h0: std_div = 17'h0208d;   // 8333
         3'h1: std_div = 17'h01047;   // 4167
         3'h2: std_div = 17'h00823;   // 2083
         3'h3: std_div = 17'h00412;   // 1042
         3'h4: std_div = 17'h00209;   // 521
         3'h5: std_div = 17'h00104;   // 260
         3'h6: std_div = 17'h000ae;   // 174
         3'h7: std_div = 17'h0005a;   // 90
      endcase
   endfunction
endpackage

//--- design/seq_divider.sv
// Restoring sequential divider, one quotient bit per clock
`timescale 1ns/100ps
module seq_divider #(
   parameter int W = 25
) (
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         start_i,
   input  wire logic [W-1:0] dividend_i,
   input  wire logic [W-1:0] divisor_i,
   output logic              done_o,
   output logic [W-1:0]      quotient_o
);
   typedef struct packed {
      logic [W-1:0] rem;
      logic [W-1:0] quo;
      logic [W-1:0] dsr;
      logic [5:0]   cnt;
      logic         busy;
      logic         done;
   } div_state_t;

   div_state_t s_q;
   div_state_t s_d;
   logic [W:0] trial;

   // ==========================================================
   // Shift-subtract step; a new start restarts the division
   always_comb begin
      s_d   = s_q;
      trial = {s_q.rem, s_q.quo[W-1]} - {1'b0, s_q.dsr};
      s_d.done = 1'b0;
      if (start_i) begin
         s_d.rem  = '0;
         s_d.quo  = dividend_i;
         s_d.dsr  = divisor_i;
         s_d.cnt  = 6'(W);
         s_d.busy = 1'b1;
      end else if (s_q.busy) begin
         if (!trial[W]) begin
            s_d.rem = trial[W-1:0];
            s_d.quo = {s_q.quo[W-2:0], 1'b1};
         end else begin
            s_d.rem = {s_q.rem[W-2:0], s_q.quo[W-1]};
            s_d.quo = {s_q.quo[W-2:0], 1'b0};
         end
         s_d.cnt = s_q.cnt - 6'h01;
         if (s_q.cnt == 6'h01) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) s_q <= '0;
      else s_q <= s_d;
   end

   assign done_o     = s_q.done;
   assign quotient_o = s_q.quo;
endmodule

//--- design/serial_byte_rx.sv
// Serial byte receiver: start, eight data bits, optional parity slot, stop
`timescale 1ns/100ps
module serial_byte_rx #(
   parameter int DW = 17
) (
   input  wire logic          sys_clk_i,
   input  wire logic          sys_rst_i,
   input  wire logic          rxd_i,
   input  wire logic [DW-1:0] bit_div_i,
   input  wire logic          parity_slot_i,
   output logic [7:0]         byte_o,
   output logic               byte_valid_o,
   output logic               busy_o
);
   typedef struct packed {
      logic          busy;
      logic [DW-1:0] tmr;
      logic [3:0]    bitn;
      logic [8:0]    shf;
      logic [7:0]    data;
      logic          valid;
   } rx_state_t;

   rx_state_t s_q;
   rx_state_t s_d;
   logic [3:0] last_bit;

   // ==========================================================
   // Sample mid-bit; the parity slot is skipped, never checked
   always_comb begin
      s_d       = s_q;
      s_d.valid = 1'b0;
      last_bit  = parity_slot_i ? 4'h9 : 4'h8;
      if (!s_q.busy) begin
         if (!rxd_i) begin
            s_d.busy = 1'b1;
            s_d.bitn = 4'h0;
            s_d.tmr  = {1'b0, bit_div_i[DW-1:1]};
         end
      end else if (s_q.tmr != '0) begin
         s_d.tmr = s_q.tmr - 1'b1;
      end else begin
         s_d.tmr = bit_div_i - 1'b1;
         if (s_q.bitn == 4'h0 && rxd_i) begin
            s_d.busy = 1'b0;                     // Glitch, not a start bit
         end else if (s_q.bitn == last_bit + 4'h1) begin
            s_d.busy  = 1'b0;
            s_d.valid = 1'b1;
            s_d.data  = parity_slot_i ? s_q.shf[7:0] : s_q.shf[8:1];
         end else begin
            s_d.bitn = s_q.bitn + 4'h1;
            if (s_q.bitn != 4'h0) s_d.shf = {rxd_i, s_q.shf[8:1]};
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) s_q <= '0;
      else s_q <= s_d;
   end

   assign byte_o       = s_q.data;
   assign byte_valid_o = s_q.valid;
   assign busy_o       = s_q.busy;
endmodule

//--- design/host_serial_port_config.sv
// Host serial port: rate select, packet gap timer, framing and pull-up settings
`timescale 1ns/100ps
// What this block does
// - Codes zero to seven select standard rates
// - Larger values are literal rates, highest achievable not above the request
// - Literal requests limited to 0x80 through 0x3D090
// - Stored rate setting holds the achieved rate
// - Reading rate returns stored achieved value
// - New rate applies only after exit acknowledged
// - Code seven really runs at 111,111 baud
// - Serial rate never alters radio rate
// - Send after programmed silence with buffered data
// - Send at once when 100 bytes buffered
// - Zero silence sends every character alone unless 100 bytes are buffered
// - Interface mode transparent, framed, or escaped framed
// - Parity only sets framing, never checked
// - Pull map bits assigned to fixed lines
// - Map bit one enables pull-up, reset all ones
// - Pulls only act on inputs or disabled lines
module host_serial_port_config (
   input  wire logic                     sys_clk_i,
   input  wire logic                     sys_rst_i,
   input  host_serial_pkg::cfg_req_t     cfg_i,
   input  wire logic                     exit_command_mode_i,
   input  wire logic                     host_rxd_i,
   input  wire logic [7:0]               line_is_input_i,
   input  wire logic                     pkt_ready_i,
   output logic                          cfg_busy_o,
   output logic                          cfg_err_o,
   output logic [19:0]                   host_rate_select_o,
   output logic [7:0]                    packet_gap_timeout_o,
   output logic [1:0]                    framed_interface_select_o,
   output logic [2:0]                    parity_select_o,
   output logic [7:0]                    pullup_enable_map_o,
   output logic [7:0]                    pull_direction_map_o,
   output logic [host_serial_pkg::DIV_W-1:0] bit_div_o,
   output logic [7:0]                    pullup_en_o,
   output logic [7:0]                    pull_dir_o,
   output logic                          tx_start_o,
   output logic                          pkt_valid_o,
   output host_serial_pkg::pkt_beat_t    pkt_o,
   output logic                          overrun_o
);
   localparam int DW = host_serial_pkg::DIV_W;
   localparam int QW = 25;

   typedef struct packed {
      logic                         sync1;
      logic                         sync2;
      host_serial_pkg::rate_fsm_t   fsm;
      logic [19:0]                  rate_set;
      logic [19:0]                  lit_req;
      logic [DW-1:0]                pend_div;
      logic [DW-1:0]                act_div;
      logic [7:0]                   gap;
      logic [1:0]                   iface;
      logic [2:0]                   parity;
      logic [7:0]                   pull_map;
      logic [7:0]                   dir_map;
      logic [7:0]                   pull_en;
      logic [7:0]                   pull_dir;
      logic [host_serial_pkg::PKT_MAX-1:0][7:0] mem;
      logic [6:0]                   wr;
      logic [6:0]                   rd;
      logic [6:0]                   cnt;
      logic [6:0]                   remain;
      logic                         sending;
      logic                         start;
      logic                         err;
      logic                         ovr;
      logic [host_serial_pkg::CHAR_W-1:0] sil;
      logic [7:0]                   chars;
   } top_state_t;

   top_state_t s_q;
   top_state_t s_d;

   logic          div_start;
   logic [QW-1:0] div_num;
   logic [QW-1:0] div_den;
   logic          div_done;
   logic [QW-1:0] div_quo;
   logic [7:0]    rx_byte;
   logic          rx_valid;
   logic          rx_busy;
   logic          launch_ok;
   logic [6:0]    launch_len;
   logic          pop;
   logic [host_serial_pkg::CHAR_W-1:0] char_cycles;

   function automatic logic [6:0] wrap_inc(input logic [6:0] p);
      wrap_inc = (p == 7'(host_serial_pkg::PKT_MAX - 1)) ? 7'h00 : p + 7'h01;
   endfunction

   // ==========================================================
   // Rate arithmetic: one divider shared by both steps
   seq_divider #(.W(QW)) u_div (
      .sys_clk_i  (sys_clk_i),
      .sys_rst_i  (sys_rst_i),
      .start_i    (div_start),
      .dividend_i (div_num),
      .divisor_i  (div_den),
      .done_o     (div_done),
      .quotient_o (div_quo)
   );

   // ==========================================================
   // Host receive line, always on the active rate
   serial_byte_rx #(.DW(DW)) u_rx (
      .sys_clk_i     (sys_clk_i),
      .sys_rst_i     (sys_rst_i),
      .rxd_i         (s_q.sync2),
      .bit_div_i     (s_q.act_div),
      .parity_slot_i (s_q.parity != 3'h0),
      .byte_o        (rx_byte),
      .byte_valid_o  (rx_valid),
      .busy_o        (rx_busy)
   );

   // Divider operands: the divisor is rounded up from the request and the achieved
   // rate rounded down from it, so the stored rate never overstates the real one
   always_comb begin
      div_start = 1'b0;
      div_num   = '0;
      div_den   = '1;
      if (s_q.fsm == host_serial_pkg::RATE_DIV1 && !div_done && s_q.lit_req != '0) begin
         div_start = (s_q.pend_div == '1);
      end
      if (s_q.fsm == host_serial_pkg::RATE_DIV1) begin
         div_num = QW'(host_serial_pkg::CLK_HZ) + QW'(s_q.lit_req) - QW'(1);
         div_den = QW'(s_q.lit_req);
      end else if (s_q.fsm == host_serial_pkg::RATE_DIV2) begin
         div_num = QW'(host_serial_pkg::CLK_HZ);
         div_den = QW'(s_q.pend_div);
         div_start = (s_q.rate_set == '1);
      end
   end

   // Character time in clocks at the active rate
   assign char_cycles = host_serial_pkg::CHAR_W'(s_q.act_div) *
                        host_serial_pkg::CHAR_W'(host_serial_pkg::BITS_PER_CHAR);

   // Packet launch conditions
   always_comb begin
      launch_ok  = 1'b0;
      launch_len = s_q.cnt;
      if (!s_q.sending && s_q.cnt != 7'h00) begin
         if (s_q.cnt >= 7'(host_serial_pkg::PKT_MAX)) begin
            launch_ok = 1'b1;
         end else if (s_q.gap == 8'h00) begin
            launch_ok  = 1'b1;
            launch_len = 7'h01;
         end else if (s_q.chars >= s_q.gap) begin
            launch_ok = 1'b1;
         end
      end
   end

   assign pop = s_q.sending && pkt_ready_i;

   // ==========================================================
   // Next state
   always_comb begin
      s_d       = s_q;
      s_d.sync1 = host_rxd_i;
      s_d.sync2 = s_q.sync1;
      s_d.start = 1'b0;
      s_d.err   = 1'b0;
      s_d.ovr   = 1'b0;

      // Settings writes; refused with an error pulse while a rate is being worked out
      if (cfg_i.we && s_q.fsm == host_serial_pkg::RATE_IDLE) begin
         unique case (cfg_i.sel)
            host_serial_pkg::SEL_RATE: begin
               if (cfg_i.data <= host_serial_pkg::RATE_STD_MAX) begin
                  s_d.rate_set = cfg_i.data;
                  s_d.pend_div = host_serial_pkg::std_div(cfg_i.data[2:0]);
               end else if (cfg_i.data >= host_serial_pkg::RATE_LIT_MIN &&
                            cfg_i.data <= host_serial_pkg::RATE_LIT_MAX) begin
                  s_d.lit_req  = cfg_i.data;
                  s_d.pend_div = '1;
                  s_d.fsm      = host_serial_pkg::RATE_DIV1;
               end else begin
                  s_d.err = 1'b1;
               end
            end
            host_serial_pkg::SEL_GAP: s_d.gap = cfg_i.data[7:0];
            host_serial_pkg::SEL_IFACE: begin
               if (cfg_i.data <= 20'(host_serial_pkg::IFACE_MAX)) s_d.iface = cfg_i.data[1:0];
               else s_d.err = 1'b1;
            end
            host_serial_pkg::SEL_PARITY: begin
               if (cfg_i.data <= 20'(host_serial_pkg::PARITY_MAX)) s_d.parity = cfg_i.data[2:0];
               else s_d.err = 1'b1;
            end
            host_serial_pkg::SEL_PULL_MAP: s_d.pull_map = cfg_i.data[7:0];
            host_serial_pkg::SEL_DIR_MAP:  s_d.dir_map  = cfg_i.data[7:0];
            default: s_d.err = 1'b1;
         endcase
      end else if (cfg_i.we) begin
         s_d.err = 1'b1;
      end

      // Literal rate: divisor first, then the rate that divisor really gives
      unique case (s_q.fsm)
         host_serial_pkg::RATE_IDLE: ;
         host_serial_pkg::RATE_DIV1: begin
            if (div_done) begin
               s_d.pend_div = (div_quo == '0) ? DW'(1) : div_quo[DW-1:0];
               s_d.rate_set = '1;
               s_d.fsm      = host_serial_pkg::RATE_DIV2;
            end else begin
               // Start marker used up once; restarting would never let the division end
               if (div_start) s_d.pend_div = '0;
            end
         end
         host_serial_pkg::RATE_DIV2: begin
            if (div_start) s_d.rate_set = '0;
            if (div_done) begin
               s_d.rate_set = div_quo[19:0];
               s_d.fsm      = host_serial_pkg::RATE_IDLE;
            end
         end
      endcase

      // New divisor only after exit from command mode is acknowledged
      if (exit_command_mode_i && s_q.fsm == host_serial_pkg::RATE_IDLE) begin
         s_d.act_div = s_q.pend_div;
      end

      // Pulls only reach lines that are inputs or disabled
      s_d.pull_en  = s_q.pull_map & line_is_input_i;
      s_d.pull_dir = s_q.dir_map & line_is_input_i;

      // Silence timer in whole character times
      if (rx_busy || rx_valid) begin
         s_d.sil   = '0;
         s_d.chars = 8'h00;
      end else if (s_q.sil + 1'b1 >= char_cycles) begin
         s_d.sil = '0;
         if (s_q.chars != 8'hff) s_d.chars = s_q.chars + 8'h01;
      end else begin
         s_d.sil = s_q.sil + 1'b1;
      end

      // Drain side
      if (pop) begin
         s_d.rd     = wrap_inc(s_q.rd);
         s_d.remain = s_q.remain - 7'h01;
         if (s_q.remain == 7'h01) s_d.sending = 1'b0;
      end
      if (launch_ok) begin
         s_d.sending = 1'b1;
         s_d.remain  = launch_len;
         s_d.start   = 1'b1;
         s_d.chars   = 8'h00;
      end

      // Fill side; a byte with no room is dropped and flagged
      s_d.cnt = s_q.cnt - (pop ? 7'h01 : 7'h00);
      if (rx_valid) begin
         if (s_q.cnt < 7'(host_serial_pkg::PKT_MAX) || pop) begin
            s_d.mem[s_q.wr] = rx_byte;
            s_d.wr          = wrap_inc(s_q.wr);
            s_d.cnt         = s_d.cnt + 7'h01;
         end else begin
            s_d.ovr = 1'b1;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s_q          <= '0;
         s_q.sync1    <= 1'b1;
         s_q.sync2    <= 1'b1;
         s_q.fsm      <= host_serial_pkg::RATE_IDLE;
         s_q.rate_set <= host_serial_pkg::RATE_RST;
         s_q.pend_div <= host_serial_pkg::std_div(host_serial_pkg::RATE_RST[2:0]);
         s_q.act_div  <= host_serial_pkg::std_div(host_serial_pkg::RATE_RST[2:0]);
         s_q.gap      <= host_serial_pkg::GAP_RST;
         s_q.iface    <= host_serial_pkg::IFACE_RST;
         s_q.parity   <= host_serial_pkg::PARITY_RST;
         s_q.pull_map <= host_serial_pkg::PULL_MAP_RST;
         s_q.dir_map  <= host_serial_pkg::DIR_MAP_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs; rate changes here never touch any radio-side setting
   assign cfg_busy_o                = (s_q.fsm != host_serial_pkg::RATE_IDLE);
   assign cfg_err_o                 = s_q.err;
   assign host_rate_select_o        = s_q.rate_set;
   assign packet_gap_timeout_o      = s_q.gap;
   assign framed_interface_select_o = s_q.iface;
   assign parity_select_o           = s_q.parity;
   assign pullup_enable_map_o       = s_q.pull_map;
   assign pull_direction_map_o      = s_q.dir_map;
   assign bit_div_o                 = s_q.act_div;
   assign pullup_en_o               = s_q.pull_en;
   assign pull_dir_o                = s_q.pull_dir;
   assign tx_start_o                = s_q.start;
   assign pkt_valid_o               = s_q.sending;
   assign pkt_o.data                = s_q.mem[s_q.rd];
   assign pkt_o.last                = s_q.sending && (s_q.remain == 7'h01);
   assign overrun_o                 = s_q.ovr;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_std_code;
      cfg_i.we && !cfg_busy_o && cfg_i.sel == host_serial_pkg::SEL_RATE &&
      cfg_i.data <= host_serial_pkg::RATE_STD_MAX
      |=> host_rate_select_o == $past(cfg_i.data) &&
          s_q.pend_div == host_serial_pkg::std_div($past(cfg_i.data[2:0]));
   endproperty
   a_std_code: assert property (p_std_code) else $error("standard code not applied");

   property p_code7;
      s_q.rate_set == 20'h00007 && !cfg_busy_o |-> s_q.pend_div == 17'd90;
   endproperty
   a_code7: assert property (p_code7) else $error("code 7 divisor wrong");

   property p_bad_literal;
      cfg_i.we && !cfg_busy_o && cfg_i.sel == host_serial_pkg::SEL_RATE &&
      (cfg_i.data > host_serial_pkg::RATE_LIT_MAX ||
       (cfg_i.data > host_serial_pkg::RATE_STD_MAX && cfg_i.data < host_serial_pkg::RATE_LIT_MIN))
      |=> cfg_err_o && $stable(host_rate_select_o) && !cfg_busy_o;
   endproperty
   a_bad_literal: assert property (p_bad_literal) else $error("bad literal accepted");

   property p_literal_done;
      s_q.fsm == host_serial_pkg::RATE_DIV2 && div_done
      |=> host_rate_select_o == $past(div_quo[19:0]) && !cfg_busy_o;
   endproperty
   a_literal_done: assert property (p_literal_done) else $error("achieved rate not stored");

   property p_hold_rate;
      !exit_command_mode_i |=> $stable(bit_div_o);
   endproperty
   a_hold_rate: assert property (p_hold_rate) else $error("rate changed without exit");

   property p_full_send;
      s_q.cnt >= 7'd100 && !pkt_valid_o |=> tx_start_o && pkt_valid_o;
   endproperty
   a_full_send: assert property (p_full_send) else $error("full buffer not sent");

   property p_zero_gap;
      s_q.gap == 8'h00 && s_q.cnt != 7'h00 && s_q.cnt < 7'd100 && !pkt_valid_o
      |=> pkt_valid_o && pkt_o.last;
   endproperty
   a_zero_gap: assert property (p_zero_gap) else $error("zero gap not single byte");

   property p_pull_gate;
      ##1 pullup_en_o == ($past(pullup_enable_map_o) & $past(line_is_input_i));
   endproperty
   a_pull_gate: assert property (p_pull_gate) else $error("pull-up gating wrong");
endmodule

//--- test/host_uart_model.sv
// Host processor model driving the serial data-in line of the port
`timescale 1ns/100ps
module host_uart_model (
   input  wire logic sys_clk_i,
   output logic      txd_o
);
   // ==========================================
   // Idle high between frames, so no false start bit reaches the port
   initial txd_o = 1'b1;

   // One 8N1 frame, LSB first; div is the bit period in clocks
   task automatic send_byte(input logic [7:0] b, input int div);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      @(posedge sys_clk_i);
      for (int i = 0; i < 10; i++) begin
         txd_o <= frame[i];
         repeat (div) @(posedge sys_clk_i);
      end
   endtask
endmodule

//--- test/test_host_serial_port_config.sv
// Self-checking bench for the host serial port configuration block
`timescale 1ns/100ps
module test_host_serial_port_config;
   logic sys_clk_i, sys_rst_i, exit_i, rxd, busy, err, tx_start, pkt_valid, overrun;
   host_serial_pkg::cfg_req_t  cfg;
   host_serial_pkg::pkt_beat_t pkt;
   logic [19:0] rate;
   logic [16:0] bit_div;
   logic [7:0]  gap, pmap, dmap, pen, pdir, is_in;
   logic [2:0]  par;
   logic [1:0]  iface;
   int fail_count = 0;
   int cmp_count  = 0;

   // ==========================================
   // Clock at 100 ns; bus inputs start quiet with reset asserted
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      sys_rst_i = 1'b1; cfg = '0; exit_i = 1'b0; is_in = 8'h00;
   end

   host_uart_model i_host_uart_model (.sys_clk_i(sys_clk_i), .txd_o(rxd));
   host_serial_port_config i_host_serial_port_config (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .cfg_i(cfg), .exit_command_mode_i(exit_i), .host_rxd_i(rxd),
      .line_is_input_i(is_in), .pkt_ready_i(1'b1), .cfg_busy_o(busy), .cfg_err_o(err),
      .host_rate_select_o(rate), .packet_gap_timeout_o(gap),
      .framed_interface_select_o(iface), .parity_select_o(par), .pullup_enable_map_o(pmap),
      .pull_direction_map_o(dmap), .bit_div_o(bit_div), .pullup_en_o(pen),
      .pull_dir_o(pdir), .tx_start_o(tx_start), .pkt_valid_o(pkt_valid), .pkt_o(pkt),
      .overrun_o(overrun));

   // ==========================================
   // Shared tasks
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // A wait that ran out ends the run at once as a failure
   task automatic timeout_chk(input logic done);
      if (done !== 1'b1) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, done, 1'b1);
         report_and_stop();
      end
   endtask

   // Write pulse held one edge; returns just after the edge that takes it,
   // while the one-cycle error pulse still stands
   task automatic wr(input host_serial_pkg::cfg_sel_t s, input logic [19:0] d);
      @(posedge sys_clk_i) cfg <= '{1'b1, s, d};
      @(posedge sys_clk_i) cfg.we <= 1'b0;
      #1;
   endtask

   task automatic apply_rate();
      @(posedge sys_clk_i) exit_i <= 1'b1;
      @(posedge sys_clk_i) exit_i <= 1'b0;
      @(posedge sys_clk_i) #1;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_literal();
      wr(host_serial_pkg::SEL_RATE, 20'h0012c);
      check(busy, 20'h1);
      for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge sys_clk_i) #1;
      timeout_chk(busy === 1'b0);
      check(rate, 20'h0012b);
      check(bit_div, 20'h00412);
      $display("literal rate test done");
   endtask

   task automatic t_rate();
      wr(host_serial_pkg::SEL_RATE, 20'h00010);
      check(err, 20'h1);
      wr(host_serial_pkg::SEL_RATE, 20'h00004);
      check(rate, 20'h00004);
      check(bit_div, 20'h00412);
      apply_rate();
      check(bit_div, 20'h00209);
      wr(host_serial_pkg::SEL_RATE, 20'h00007);
      apply_rate();
      check(bit_div, 20'h0005a);
      $display("standard rate test done");
   endtask

   task automatic t_fields();
      wr(host_serial_pkg::SEL_IFACE, 20'h00003);
      check(err, 20'h1);
      wr(host_serial_pkg::SEL_IFACE, 20'h00002);
      check(iface, 20'h2);
      wr(host_serial_pkg::SEL_PARITY, 20'h00005);
      check(err, 20'h1);
      @(posedge sys_clk_i) is_in <= 8'h3c;
      wr(host_serial_pkg::SEL_PULL_MAP, 20'h0006f);
      check(pmap, 20'h0006f);
      @(posedge sys_clk_i) #1;
      check(pen, 20'h0002c);
      check(pdir, 20'h0003c);
      $display("field test done");
   endtask

   // Zero gap: a lone byte leaves at once as a one-byte packet
   task automatic t_packet();
      wr(host_serial_pkg::SEL_GAP, 20'h00000);
      fork
         i_host_uart_model.send_byte(8'ha5, 90);
      join_none
      for (int i = 0; i < 3000 && tx_start !== 1'b1; i++) @(posedge sys_clk_i) #1;
      timeout_chk(tx_start === 1'b1);
      check(tx_start, 20'h1);
      check({pkt_valid, pkt.data, pkt.last}, 20'h0034b);
      $display("packet test done");
   endtask

   // Gap of one character: two bytes in a row leave as one two-byte packet
   task automatic t_gap();
      wr(host_serial_pkg::SEL_GAP, 20'h00001);
      fork
         begin
            i_host_uart_model.send_byte(8'h3c, 90);
            i_host_uart_model.send_byte(8'hc3, 90);
         end
      join_none
      for (int i = 0; i < 5000 && tx_start !== 1'b1; i++) @(posedge sys_clk_i) #1;
      timeout_chk(tx_start === 1'b1);
      check({pkt_valid, pkt.data, pkt.last}, 20'h00278);
      @(posedge sys_clk_i) #1;
      check({pkt_valid, pkt.data, pkt.last}, 20'h00387);
      @(posedge sys_clk_i) #1;
      check({pkt_valid, overrun}, 20'h0);
      $display("gap test done");
   endtask

   // ==========================================
   // Main sequence; the consumer stays ready, so no flow control is needed
   initial begin
      repeat (20) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i) #1;
      check(rate, 20'h00003);
      check(gap, 20'h00003);
      check({iface, par}, 20'h0);
      check(pmap, 20'h000ff);
      check(dmap, 20'h000ff);
      $display("reset test done");
      t_literal();
      t_rate();
      t_fields();
      t_packet();
      t_gap();
      report_and_stop();
   end
endmodule
